//--- verilog/stap_top.sv
`timescale 1ns/1ps
`include "stap_consts.svh"

// ****************************************************************
// Scan test access port with instruction logic and pin control.
// ****************************************************************

// Functional notes
// - Bypass instruction routes TDI through one bypass stage to TDO.
// - Bypass stage loads zero in capture-DR, so zero shifts out first.
// - Clamp selects bypass; pins driven from previously loaded boundary values.
// - Outputs-off instruction floats every output and selects bypass.
// - Sample snapshot is not provided; preload still works.
// - Output float pin during system reset floats all outputs.
// - Power-up detector resets system and scan logic; TMS ignored meanwhile.
// - Low-power halt allowed only while controller sits in test-logic-reset.
// - Test clock is never gated during low-power halt.
// - Five rising edges with TMS high force test-logic-reset.
// - TMS held high keeps the controller in test-logic-reset.
// - Three-bit instruction register, no parity, fixed code decoding.
// - Test-logic-reset presets instruction outputs to all ones, bypass.
// - Capture-IR loads the clamp code; outputs change only in update-IR or test-logic-reset.
// - External test holds internal system logic in reset.
module stap_top
(
    input wire logic ref_clk_i, // System clock, 20 MHz.
    input wire logic rst_n_i, // Synchronous reset, active low.
    input wire logic tck_i, // Test clock from the tester.
    input wire logic tms_i, // Test mode select.
    input wire logic tdi_i, // Test data in.
    input wire logic trst_n_i, // Optional test reset, active low.
    input wire logic por_i, // Power-up detector output, active high.
    input wire logic output_float_pin_i, // Float request pin, active high.
    input wire logic sys_hard_reset_i, // System reset level, active high.
    input wire logic low_power_halt_op_i, // Core request for low-power halt.
    input wire logic [`STAP_BSR_LEN-1:0] core_data_i, // Normal pin data from the core.
    input wire logic [`STAP_BSR_LEN-1:0] core_oe_n_i, // Normal pin enables, low drives.
    input wire logic [`STAP_BSR_LEN-1:0] pin_data_i, // Levels seen on the pins.
    output logic tdo_o, // Test data out.
    output logic tdo_oe_n_o, // Test data out enable, low drives.
    output logic [`STAP_BSR_LEN-1:0] pin_data_o, // Data towards the pads.
    output logic [`STAP_BSR_LEN-1:0] pin_oe_n_o, // Pad enables, low drives.
    output logic sys_reset_o, // Holds the system logic in reset.
    output logic low_power_halt_o // Low-power halt granted.
);

    // ****************************************************************
    // Instruction decoding.
    // ****************************************************************

    function automatic stap_pkg::stap_instr_e decode_ir(input logic [`STAP_IR_W-1:0] code);
        stap_pkg::stap_instr_e ins;
        ins = stap_pkg::INS_CLAMP;
        if (code[1])
            ins = stap_pkg::INS_BYPASS;
        else if (code == `STAP_IR_EXTEST)
            ins = stap_pkg::INS_EXTEST;
        else if (code == `STAP_IR_SAMPLE)
            ins = stap_pkg::INS_SAMPLE;
        else if (code == `STAP_IR_HIZ)
            ins = stap_pkg::INS_HIZ;
        return ins;
    endfunction

    // ****************************************************************
    // Controller and its reset.
    // ****************************************************************

    stap_tap_if tap ();

    logic tap_rst_n;

    // test reset
    // Either source forces test-logic-reset at once and holds it, so TMS has no effect.
    assign tap_rst_n = trst_n_i & ~por_i;

    stap_tap_fsm u_fsm
    (
        .tck_i(tck_i),
        .tap_rst_n_i(tap_rst_n),
        .tms_i(tms_i),
        .tap(tap.ctl)
    );

    // ****************************************************************
    // Instruction register, test clock domain.
    // ****************************************************************

    logic [`STAP_IR_W-1:0] ir_sh_r;
    logic [`STAP_IR_W-1:0] ir_upd_r;
    stap_pkg::stap_instr_e ins;
    logic sel_bsr;

    always_ff @(posedge tck_i or negedge tap_rst_n)
    begin
        if (!tap_rst_n)
            ir_sh_r <= `STAP_IR_CLAMP;
        else if (tap.capture_ir)
            ir_sh_r <= `STAP_IR_CLAMP;
        else if (tap.shift_ir)
            ir_sh_r <= {tdi_i, ir_sh_r[`STAP_IR_W-1:1]};
    end

    // preset to bypass
    // The parallel outputs move only in update-IR or test-logic-reset, never while shifting.
    always_ff @(posedge tck_i or negedge tap_rst_n)
    begin
        if (!tap_rst_n)
            ir_upd_r <= `STAP_IR_RESET;
        else if (tap.tlr)
            ir_upd_r <= `STAP_IR_RESET;
        else if (tap.update_ir)
            ir_upd_r <= ir_sh_r;
    end

    assign ins = decode_ir(ir_upd_r);

    // outputs-off uses bypass
    // Only external test and sample/preload put the boundary register in the path.
    assign sel_bsr = (ins == stap_pkg::INS_EXTEST) || (ins == stap_pkg::INS_SAMPLE);

    // ****************************************************************
    // Data registers, test clock domain.
    // ****************************************************************

    logic byp_r;
    logic [`STAP_BSR_LEN-1:0] bsr_sh_r;
    logic [`STAP_BSR_LEN-1:0] bsr_upd_r;
    logic upd_tgl_r;

    always_ff @(posedge tck_i or negedge tap_rst_n)
    begin
        if (!tap_rst_n)
            byp_r <= 1'h0;
        else if (tap.capture_dr && !sel_bsr)
            byp_r <= 1'h0;
        else if (tap.shift_dr && !sel_bsr)
            byp_r <= tdi_i;
    end

    // unsynchronised capture
    // Pins are captured only under external test, straight off the pads; the tester owns
    // the timing relation. Under sample/preload the chain keeps its contents for preload.
    always_ff @(posedge tck_i or negedge tap_rst_n)
    begin
        if (!tap_rst_n)
            bsr_sh_r <= '0;
        else if (tap.capture_dr && ins == stap_pkg::INS_EXTEST)
            bsr_sh_r <= pin_data_i;
        else if (tap.shift_dr && sel_bsr)
            bsr_sh_r <= {tdi_i, bsr_sh_r[`STAP_BSR_LEN-1:1]};
    end

    // Update latch; each load flips a toggle that announces the new word to the system side.
    always_ff @(posedge tck_i or negedge tap_rst_n)
    begin
        if (!tap_rst_n)
        begin
            bsr_upd_r <= '0;
            upd_tgl_r <= 1'h0;
        end
        else if (tap.update_dr && sel_bsr)
        begin
            bsr_upd_r <= bsr_sh_r;
            upd_tgl_r <= ~upd_tgl_r;
        end
    end

    // ****************************************************************
    // Serial output on the falling test clock.
    // ****************************************************************

    logic tdo_r;
    logic tdo_oe_n_r;

    // TDO on falling edge
    // Half a period of margin lets the tester sample on its next rising edge.
    always_ff @(negedge tck_i or negedge tap_rst_n)
    begin
        if (!tap_rst_n)
        begin
            tdo_r <= 1'h0;
            tdo_oe_n_r <= 1'h1;
        end
        else
        begin
            tdo_oe_n_r <= ~(tap.shift_dr | tap.shift_ir);
            if (tap.shift_ir)
                tdo_r <= ir_sh_r[0];
            else if (sel_bsr)
                tdo_r <= bsr_sh_r[0];
            else
                tdo_r <= byp_r;
        end
    end

    assign tdo_o = tdo_r;
    assign tdo_oe_n_o = tdo_oe_n_r;

    // ****************************************************************
    // Crossing into the system clock domain.
    // ****************************************************************

    logic [`STAP_SYNC_W-1:0] sy_in;
    logic [`STAP_SYNC_W-1:0] sy_out;

    // Levels are flopped in their own domain where possible; pins arrive raw.
    always_comb
    begin
        sy_in = '0;
        sy_in[`STAP_SY_POR] = por_i;
        sy_in[`STAP_SY_FLOAT] = output_float_pin_i;
        sy_in[`STAP_SY_SYSRST] = sys_hard_reset_i;
        sy_in[`STAP_SY_EXTEST] = (ins == stap_pkg::INS_EXTEST);
        sy_in[`STAP_SY_CLAMP] = (ins == stap_pkg::INS_CLAMP);
        sy_in[`STAP_SY_HIZ] = (ins == stap_pkg::INS_HIZ);
        sy_in[`STAP_SY_TLR] = tap.tlr;
        sy_in[`STAP_SY_UPD] = upd_tgl_r;
    end

    stap_sync u_sync
    (
        .clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .d_i(sy_in),
        .q_o(sy_out)
    );

    logic upd_seen_r;
    logic [`STAP_BSR_LEN-1:0] bsr_cap_r;

    // The update word is stable for many test clocks after its toggle flips, so it is
    // copied once the synchronised toggle shows the change.
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            upd_seen_r <= 1'h0;
            bsr_cap_r <= '0;
        end
        else
        begin
            upd_seen_r <= sy_out[`STAP_SY_UPD];
            if (sy_out[`STAP_SY_UPD] != upd_seen_r)
                bsr_cap_r <= bsr_upd_r;
        end
    end

    // ****************************************************************
    // Pin control, system clock domain.
    // ****************************************************************

    logic [`STAP_BSR_LEN-1:0] pin_data_r;
    logic [`STAP_BSR_LEN-1:0] pin_oe_n_r;
    logic float_req;
    logic scan_drive;

    assign float_req = sy_out[`STAP_SY_FLOAT] & (sy_out[`STAP_SY_SYSRST] | sy_out[`STAP_SY_POR]);
    assign scan_drive = sy_out[`STAP_SY_EXTEST] | sy_out[`STAP_SY_CLAMP];

    // all drivers enabled
    // Under scan control every cell drives its loaded value; contention is the tester's care.
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            pin_data_r <= '0;
            pin_oe_n_r <= '1;
        end
        else if (sy_out[`STAP_SY_HIZ] || float_req)
        begin
            pin_data_r <= '0;
            pin_oe_n_r <= '1;
        end
        else if (scan_drive)
        begin
            pin_data_r <= bsr_cap_r;
            pin_oe_n_r <= '0;
        end
        else
        begin
            pin_data_r <= core_data_i;
            pin_oe_n_r <= core_oe_n_i;
        end
    end

    assign pin_data_o = pin_data_r;
    assign pin_oe_n_o = pin_oe_n_r;

    // ****************************************************************
    // System reset and low-power halt.
    // ****************************************************************

    logic sys_reset_r;
    logic lp_halt_r;

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            sys_reset_r <= 1'h1;
        else
            sys_reset_r <= sy_out[`STAP_SY_POR] | sy_out[`STAP_SY_EXTEST];
    end

    // test clock kept running
    // The halt never gates the test clock, so the controller keeps answering during it;
    // leaving test-logic-reset simply withdraws the halt.
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            lp_halt_r <= 1'h0;
        else
            lp_halt_r <= low_power_halt_op_i & sy_out[`STAP_SY_TLR];
    end

    assign sys_reset_o = sys_reset_r;
    assign low_power_halt_o = lp_halt_r;

endmodule

//--- shared/stap_consts.svh
`ifndef STAP_CONSTS_SVH
`define STAP_CONSTS_SVH

// ****************************************************************
// Scan port widths and lengths.
// ****************************************************************
`define STAP_IR_W 3
`define STAP_BSR_LEN 196

// ****************************************************************
// Instruction codes and the value preset in test-logic-reset.
// ****************************************************************
`define STAP_IR_EXTEST 3'h0
`define STAP_IR_SAMPLE 3'h1
`define STAP_IR_HIZ 3'h4
`define STAP_IR_CLAMP 3'h5
`define STAP_IR_RESET 3'h7

// ****************************************************************
// Bit positions inside the synchroniser bundle.
// ****************************************************************
`define STAP_SYNC_W 8
`define STAP_SY_POR 0
`define STAP_SY_FLOAT 1
`define STAP_SY_SYSRST 2
`define STAP_SY_EXTEST 3
`define STAP_SY_CLAMP 4
`define STAP_SY_HIZ 5
`define STAP_SY_TLR 6
`define STAP_SY_UPD 7

`endif

//--- shared/stap_pkg.sv
// ****************************************************************
// Types shared by the scan port modules.
// ****************************************************************
package stap_pkg;

    // Controller states of the test access port.
    typedef enum logic [3:0]
    {
        ST_TLR, ST_IDLE,
        ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
        ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR,
        ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
        ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } stap_state_e;

    // Decoded instructions.
    typedef enum logic [2:0]
    {
        INS_EXTEST, INS_SAMPLE, INS_BYPASS, INS_HIZ, INS_CLAMP
    } stap_instr_e;

endpackage

//--- shared/stap_tap_if.sv
`timescale 1ns/1ps
// ****************************************************************
// State and phase strobes from the controller to the registers.
// ****************************************************************
interface stap_tap_if;
    stap_pkg::stap_state_e state;
    logic tlr;
    logic capture_dr;
    logic shift_dr;
    logic update_dr;
    logic capture_ir;
    logic shift_ir;
    logic update_ir;

    modport ctl
    (
        output state, tlr, capture_dr, shift_dr, update_dr, capture_ir, shift_ir, update_ir
    );
    modport usr
    (
        input state, tlr, capture_dr, shift_dr, update_dr, capture_ir, shift_ir, update_ir
    );
endinterface

//--- verilog/stap_sync.sv
`timescale 1ns/1ps
`include "stap_consts.svh"
// ****************************************************************
// Two-stage level synchroniser into the system clock domain.
// ****************************************************************
module stap_sync
(
    input wire logic clk_i, // Destination clock.
    input wire logic rst_n_i, // Synchronous reset, active low.
    input wire logic [`STAP_SYNC_W-1:0] d_i, // Levels from another domain.
    output logic [`STAP_SYNC_W-1:0] q_o // Synchronised levels.
);
    logic [`STAP_SYNC_W-1:0] meta_r;
    logic [`STAP_SYNC_W-1:0] q_r;

    // The first stage feeds only the second one.
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            meta_r <= '0;
            q_r <= '0;
        end
        else
        begin
            meta_r <= d_i;
            q_r <= meta_r;
        end
    end

    assign q_o = q_r;
endmodule

//--- verilog/stap_tap_fsm.sv
`timescale 1ns/1ps
// ****************************************************************
// Sixteen-state test access port controller on the test clock.
// ****************************************************************
module stap_tap_fsm
(
    input wire logic tck_i, // Test clock.
    input wire logic tap_rst_n_i, // Asynchronous controller reset, active low.
    input wire logic tms_i, // Mode select sampled on rising test clock.
    stap_tap_if.ctl tap // State and strobes.
);
    stap_pkg::stap_state_e state_r;
    stap_pkg::stap_state_e state_nxt;

    always_ff @(posedge tck_i or negedge tap_rst_n_i)
    begin
        if (!tap_rst_n_i)
            state_r <= stap_pkg::ST_TLR;
        else
            state_r <= state_nxt;
    end

    // TMS walk; five highs from any state reach test-logic-reset.
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            stap_pkg::ST_TLR: state_nxt = tms_i ? stap_pkg::ST_TLR : stap_pkg::ST_IDLE;
            stap_pkg::ST_IDLE: state_nxt = tms_i ? stap_pkg::ST_SEL_DR : stap_pkg::ST_IDLE;
            stap_pkg::ST_SEL_DR: state_nxt = tms_i ? stap_pkg::ST_SEL_IR : stap_pkg::ST_CAP_DR;
            stap_pkg::ST_CAP_DR: state_nxt = tms_i ? stap_pkg::ST_EXIT1_DR : stap_pkg::ST_SHIFT_DR;
            stap_pkg::ST_SHIFT_DR: state_nxt = tms_i ? stap_pkg::ST_EXIT1_DR : stap_pkg::ST_SHIFT_DR;
            stap_pkg::ST_EXIT1_DR: state_nxt = tms_i ? stap_pkg::ST_UPD_DR : stap_pkg::ST_PAUSE_DR;
            stap_pkg::ST_PAUSE_DR: state_nxt = tms_i ? stap_pkg::ST_EXIT2_DR : stap_pkg::ST_PAUSE_DR;
            stap_pkg::ST_EXIT2_DR: state_nxt = tms_i ? stap_pkg::ST_UPD_DR : stap_pkg::ST_SHIFT_DR;
            stap_pkg::ST_UPD_DR: state_nxt = tms_i ? stap_pkg::ST_SEL_DR : stap_pkg::ST_IDLE;
            stap_pkg::ST_SEL_IR: state_nxt = tms_i ? stap_pkg::ST_TLR : stap_pkg::ST_CAP_IR;
            stap_pkg::ST_CAP_IR: state_nxt = tms_i ? stap_pkg::ST_EXIT1_IR : stap_pkg::ST_SHIFT_IR;
            stap_pkg::ST_SHIFT_IR: state_nxt = tms_i ? stap_pkg::ST_EXIT1_IR : stap_pkg::ST_SHIFT_IR;
            stap_pkg::ST_EXIT1_IR: state_nxt = tms_i ? stap_pkg::ST_UPD_IR : stap_pkg::ST_PAUSE_IR;
            stap_pkg::ST_PAUSE_IR: state_nxt = tms_i ? stap_pkg::ST_EXIT2_IR : stap_pkg::ST_PAUSE_IR;
            stap_pkg::ST_EXIT2_IR: state_nxt = tms_i ? stap_pkg::ST_UPD_IR : stap_pkg::ST_SHIFT_IR;
            stap_pkg::ST_UPD_IR: state_nxt = tms_i ? stap_pkg::ST_SEL_DR : stap_pkg::ST_IDLE;
            default: state_nxt = stap_pkg::ST_TLR;
        endcase
    end

    // Phase strobes decoded from the current state.
    assign tap.state = state_r;
    assign tap.tlr = (state_r == stap_pkg::ST_TLR);
    assign tap.capture_dr = (state_r == stap_pkg::ST_CAP_DR);
    assign tap.shift_dr = (state_r == stap_pkg::ST_SHIFT_DR);
    assign tap.update_dr = (state_r == stap_pkg::ST_UPD_DR);
    assign tap.capture_ir = (state_r == stap_pkg::ST_CAP_IR);
    assign tap.shift_ir = (state_r == stap_pkg::ST_SHIFT_IR);
    assign tap.update_ir = (state_r == stap_pkg::ST_UPD_IR);
endmodule

//--- tb/stap_top_assertions.sv
`timescale 1ns/1ps
`include "stap_consts.svh"
// ********
// Port checks of the scan port.
// ********
module stap_top_assertions
(
    input wire logic ref_clk_i, // System clock.
    input wire logic rst_n_i, // Reset, active low.
    input wire logic tck_i, // Test clock.
    input wire logic tms_i, // Mode select.
    input wire logic trst_n_i, // Test reset, active low.
    input wire logic por_i, // Power-up detector.
    input wire logic output_float_pin_i, // Float request.
    input wire logic sys_hard_reset_i, // System reset level.
    input wire logic low_power_halt_op_i, // Halt request.
    input wire logic tdo_o, // Test data out.
    input wire logic tdo_oe_n_o, // Data out enable, low drives.
    input wire logic [`STAP_BSR_LEN-1:0] pin_oe_n_o, // Pad enables.
    input wire logic sys_reset_o, // Core reset.
    input wire logic low_power_halt_o // Halt grant.
);
    // Reset itself is the cause here, so it cannot disable the check.
    a_rst_safe: assert property (@(posedge ref_clk_i) !rst_n_i |=>
        &pin_oe_n_o && sys_reset_o && !low_power_halt_o) else $error("unsafe outputs after reset");
    // Float request during reset floats every pad within three edges.
    a_float_in_reset: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (output_float_pin_i && sys_hard_reset_i)[*4] |-> &pin_oe_n_o) else $error("pads driven during float");
    // The power-up detector holds the core.
    a_por_core_reset: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        por_i[*4] |-> sys_reset_o) else $error("core free during power-up");
    // A grant always follows a request.
    a_halt_requested: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        low_power_halt_o |-> $past(low_power_halt_op_i)) else $error("halt without request");
    // Shifting means the port left reset state, so no halt.
    a_halt_blocked: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (!tdo_oe_n_o)[*4] |-> !low_power_halt_o) else $error("halt while shifting");
    // The power-up detector forces reset state, which allows halt.
    a_halt_in_por: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (por_i && low_power_halt_op_i)[*5] |-> low_power_halt_o) else $error("no halt during power-up");
    // Five high mode-select edges end any shifting.
    a_five_tms_reset: assert property (@(posedge tck_i) disable iff (!trst_n_i || por_i)
        tms_i[*5] |=> tdo_oe_n_o) else $error("still shifting after five ones");
    // Either test reset parks the data output.
    a_tap_reset_tdo: assert property (@(posedge tck_i) (!trst_n_i || por_i)
        |-> tdo_oe_n_o && !tdo_o) else $error("data out active in test reset");
    // Data out moves only on the falling test clock.
    a_tdo_falling: assert property (@(edge tck_i) disable iff (!trst_n_i || por_i)
        tck_i |-> $stable(tdo_o) && $stable(tdo_oe_n_o)) else $error("data out moved on high clock");
endmodule

//--- tb/stap_tester.sv
`timescale 1ns/1ps
`include "stap_consts.svh"
// ********
// Scan tester model; its clock stands low between frames.
// ********
module stap_tester
(
    input wire logic tdo_i, // Test data from the device.
    output logic tck_o, // Test clock, 48 ns.
    output logic tms_o, // Mode select.
    output logic tdi_o, // Test data to the device.
    output logic trst_n_o // Test reset, active low.
);
    localparam int HALF = 24;

    // Idle levels follow the pull-ups on mode select and data in.
    initial
    begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
        trst_n_o = 1'b1;
    end

    // One clock period; data out is read at the rising edge.
    task automatic tick(input logic tms, input logic tdi, output logic tdo);
        tms_o <= tms;
        tdi_o <= tdi;
        #HALF;
        tdo = tdo_i;
        tck_o <= 1'b1;
        #HALF;
        tck_o <= 1'b0;
    endtask

    task automatic reset5();
        logic d;
        repeat (5) tick(1'b1, 1'b1, d);
    endtask

    // Pulse test reset with a clock edge inside it.
    task automatic test_reset();
        logic d;
        trst_n_o <= 1'b0;
        tick(1'b0, 1'b1, d);
        #HALF;
        trst_n_o <= 1'b1;
    endtask

    // From idle or reset state, scan n bits bit 0 first, update, back to idle.
    task automatic scan(input logic ir, input int n, input logic [`STAP_BSR_LEN-1:0] din,
                        output logic [`STAP_BSR_LEN-1:0] dout);
        logic d;
        dout = '0;
        tick(1'b0, 1'b1, d);
        tick(1'b1, 1'b1, d);
        if (ir)
            tick(1'b1, 1'b1, d);
        tick(1'b0, 1'b1, d);
        tick(1'b0, 1'b1, d);
        for (int i = 0; i < n; i++)
            tick(i == n - 1, din[i], dout[i]);
        tick(1'b1, 1'b1, d);
        tick(1'b0, 1'b1, d);
    endtask
endmodule

//--- tb/test_scan_tap_instruction_logic.sv
`timescale 1ns/1ps
`include "stap_consts.svh"
// ********
// Self-checking bench of the scan port.
// ********
module test_scan_tap_instruction_logic;
    localparam int N = `STAP_BSR_LEN;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic por_i = 1'b0;
    logic output_float_pin_i = 1'b0;
    logic sys_hard_reset_i = 1'b0;
    logic low_power_halt_op_i = 1'b1;
    logic [N-1:0] core_data_i = '0;
    logic [N-1:0] core_oe_n_i = '0;
    logic [N-1:0] pin_data_i = '0;
    logic tck_i, tms_i, tdi_i, trst_n_i, tdo_o, tdo_oe_n_o, sys_reset_o, low_power_halt_o;
    logic [N-1:0] pin_data_o, pin_oe_n_o;
    int miscompares = 0;
    int n_checks = 0;

    // System clock; the tester's clock has its own phase.
    always #25 ref_clk_i = ~ref_clk_i;

    stap_top u_dut
    (
        .ref_clk_i, .rst_n_i, .tck_i, .tms_i, .tdi_i, .trst_n_i, .por_i, .output_float_pin_i,
        .sys_hard_reset_i, .low_power_halt_op_i, .core_data_i, .core_oe_n_i, .pin_data_i,
        .tdo_o, .tdo_oe_n_o, .pin_data_o, .pin_oe_n_o, .sys_reset_o, .low_power_halt_o
    );

    stap_tester u_tst
    (
        .tdo_i(tdo_o), .tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i), .trst_n_o(trst_n_i)
    );

    task automatic check_word(input string what, input logic [N-1:0] exp, input logic [N-1:0] got);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_bit(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask

    function automatic logic [N-1:0] rnd();
        return N'({$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom});
    endfunction

    // Expected enables: floated, driven by scan, or following the core.
    function automatic logic [N-1:0] exp_oe(input logic flt, input logic drv);
        return flt ? '1 : (drv ? '0 : core_oe_n_i);
    endfunction

    // Mode changes need a few system edges to cross; sample settled values.
    task automatic check_pads(input logic flt, input logic drv, input logic [N-1:0] w);
        repeat (8) @(posedge ref_clk_i);
        #1;
        if (!flt)
            check_word("pad data", drv ? w : core_data_i, pin_data_o);
        check_word("pad enables", exp_oe(flt, drv), pin_oe_n_o);
    endtask

    task automatic load_ir(input logic [2:0] code);
        logic [N-1:0] q;
        u_tst.scan(1'b1, 3, N'(code), q);
        check_word("captured instruction", N'(3'b101), N'(q[2:0]));
    endtask

    // A zero leads out of the bypass stage, then the first bit sent.
    task automatic check_bypass();
        logic [N-1:0] q;
        u_tst.scan(1'b0, 2, N'(2'b11), q);
        check_word("bypass out", N'(2'b10), N'(q[1:0]));
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Generous limit; the planned run takes well under a millisecond.
    initial
    begin
        #2000000;
        miscompares++;
        print_verdict();
    end

    initial
    begin
        logic [N-1:0] w;
        logic [N-1:0] r;
        logic [N-1:0] q;
        logic d;
        por_i <= 1'b1;
        void'($urandom(32'h2D5B4109));
        repeat (2) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        core_data_i <= rnd();
        core_oe_n_i <= rnd();
        output_float_pin_i <= 1'b1;
        // Mode select low is ignored while the power-up detector holds the port.
        repeat (3) u_tst.tick(1'b0, 1'b1, d);
        check_pads(1'b1, 1'b0, '0);
        check_bit("core reset", 1'b1, sys_reset_o);
        check_bit("halt grant", 1'b1, low_power_halt_o);
        @(posedge ref_clk_i);
        por_i <= 1'b0;
        sys_hard_reset_i <= 1'b1;
        check_pads(1'b1, 1'b0, '0);
        @(posedge ref_clk_i);
        sys_hard_reset_i <= 1'b0;
        check_pads(1'b0, 1'b0, '0);
        check_bit("halt grant", 1'b1, low_power_halt_o);
        check_bit("core reset", 1'b0, sys_reset_o);
        // The clock still steps the port in halt; leaving reset state drops it.
        u_tst.tick(1'b0, 1'b1, d);
        check_pads(1'b0, 1'b0, '0);
        check_bit("halt grant", 1'b0, low_power_halt_o);
        // Two high edges from idle reach select-IR, then five high mode-select edges.
        repeat (2) u_tst.tick(1'b1, 1'b0, d);
        u_tst.reset5();
        check_pads(1'b0, 1'b0, '0);
        check_bit("halt grant", 1'b1, low_power_halt_o);
        check_bypass();
        r = rnd();
        u_tst.scan(1'b0, 16, r, q);
        check_word("bypass stream", N'({r[14:0], 1'b0}), N'(q[15:0]));
        load_ir(`STAP_IR_SAMPLE);
        w = rnd();
        u_tst.scan(1'b0, N, w, q);
        r = rnd();
        u_tst.scan(1'b0, N, r, q);
        check_word("preload chain", w, q);
        check_pads(1'b0, 1'b0, '0);
        load_ir(`STAP_IR_CLAMP);
        check_pads(1'b0, 1'b1, r);
        check_bypass();
        load_ir(`STAP_IR_HIZ);
        check_pads(1'b1, 1'b0, '0);
        check_bypass();
        @(posedge ref_clk_i);
        pin_data_i <= r;
        load_ir(`STAP_IR_EXTEST);
        check_pads(1'b0, 1'b1, r);
        check_bit("core reset", 1'b1, sys_reset_o);
        u_tst.scan(1'b0, N, w, q);
        check_word("pad capture", r, q);
        check_pads(1'b0, 1'b1, w);
        for (int c = 2; c < 8; c++)
        begin
            if (c[1])
            begin
                load_ir(3'(c));
                check_bypass();
                check_pads(1'b0, 1'b0, '0);
                check_bit("core reset", 1'b0, sys_reset_o);
            end
        end
        load_ir(`STAP_IR_HIZ);
        u_tst.test_reset();
        check_pads(1'b0, 1'b0, '0);
        print_verdict();
    end
endmodule

bind stap_top stap_top_assertions u_chk
(
    .ref_clk_i, .rst_n_i, .tck_i, .tms_i, .trst_n_i, .por_i, .output_float_pin_i, .sys_hard_reset_i,
    .low_power_halt_op_i, .tdo_o, .tdo_oe_n_o, .pin_oe_n_o, .sys_reset_o, .low_power_halt_o
);
